// ---- design/sfrb_consts.svh ----
// Offsets, field positions and reset values of the second register bank.
// Assumes register indices are multiplied by four to form APB byte addresses.
`ifndef SFRB_CONSTS_SVH
`define SFRB_CONSTS_SVH

// Register indices within the bank
`define SFRB_IDX_INDIRECT_DATA 8'h80
`define SFRB_IDX_OPTION        8'h81
`define SFRB_IDX_PC_LOW        8'h82
`define SFRB_IDX_STATUS        8'h83
`define SFRB_IDX_POINTER       8'h84
`define SFRB_IDX_DIR_A         8'h85
`define SFRB_IDX_DIR_B         8'h86
`define SFRB_IDX_DIR_C         8'h87
`define SFRB_IDX_PC_HIGH_LATCH 8'h8A
`define SFRB_IDX_INT_CONTROL   8'h8B
`define SFRB_IDX_PERIPH_IE     8'h8C
`define SFRB_IDX_POWER_STATUS  8'h8E
`define SFRB_IDX_T2_PERIOD     8'h92
`define SFRB_IDX_SERIAL_ADDR   8'h93
`define SFRB_IDX_SERIAL_STATE  8'h94

// Upper three byte-address bits that select this bank
`define SFRB_BANK_SEL 3'h4

// Reset values
`define SFRB_RST_OPTION     8'hFF
`define SFRB_RST_PC_LOW     8'h00
`define SFRB_RST_STATUS     8'h18
`define SFRB_RST_POINTER    8'h00
`define SFRB_RST_DIR_A      6'h3F
`define SFRB_RST_DIR_B      8'hFF
`define SFRB_RST_DIR_C      8'hFF
`define SFRB_RST_PROGRAM_COUNTER_HIGH_LATCH     5'h00
`define SFRB_RST_INTERRUPT_CONTROL     8'h00
`define SFRB_RST_PIE        8'h00
`define SFRB_RST_T2_PERIOD  8'hFF
`define SFRB_RST_SERIAL_ADR 8'h00
`define SFRB_RST_POWER_RESET_STATUS       2'h0
`define SFRB_RST_SERIAL_ST  6'h00

// Field positions and masks
`define SFRB_STATUS_WMASK 8'hE7
`define SFRB_STATUS_TO    4
`define SFRB_STATUS_PD    3
`define SFRB_PIE_MASK     8'hCF
`define SFRB_POWER_RESET_STATUS_POR     1
`define SFRB_POWER_RESET_STATUS_BOR     0

`endif

// ---- design/sfrb_pkg.sv ----
// Types shared by the second register bank and its testbench.
// Assumes the constants header is included by each user.
package sfrb_pkg;
  // Cause of a non power-up reset, Gray coded
  typedef enum logic [1:0] {
    SFRB_RST_NONE = 2'b00,
    SFRB_RST_PIN  = 2'b01,
    SFRB_RST_WDT  = 2'b11
  } sfrb_rst_t;
endpackage

// ---- design/sfrb_mem_if.sv ----
// Carrier between the register bank and its data memory.
// Assumes a single core clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface sfrb_mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- design/sfrb_mem.sv ----
// Data memory reached through the indirect data port.
// Assumes a synchronous write and a registered read on the core clock.
`timescale 1ns/1ns
`default_nettype none
module sfrb_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic mclk,
  sfrb_mem_if.mem   port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  // Contents carry no reset, like ordinary data memory
  always_ff @(posedge mclk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  // Registered read so the data appear one edge after the address
  always_ff @(posedge mclk) begin
    rdata_reg <= store[port.addr];
  end

  assign port.rdata = rdata_reg;
endmodule // sfrb_mem
`default_nettype wire

// ---- design/sfrb_bank1.sv ----
// Second special-register bank of a small controller, reached over APB.
// Assumes one core clock; external clear pin is asynchronous, watchdog is on mclk.
`timescale 1ns/1ns
`default_nettype none
`include "sfrb_consts.svh"

// Function
// - Shared core registers answer only at this bank's addresses; other bank selects get pslverr
// - Upper latch feeds program counter bits 12:8
// - Unimplemented locations and bits read zero
// - Power-up and other resets load different values
// - Port A direction resets to all ones
// - Port B direction resets to all ones
module sfrb_bank1 (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_clear_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic [2:0]  int_flag_set,
  input  wire logic [5:0]  serial_port_state_in,
  output logic [7:0]       option_config,
  output logic [7:0]       core_status,
  output logic [12:0]      program_counter,
  output logic [5:0]       port_a_direction,
  output logic [7:0]       port_b_direction,
  output logic [7:0]       port_c_direction,
  output logic [7:0]       interrupt_control,
  output logic [7:0]       peripheral_irq_enable,
  output logic [1:0]       power_reset_status,
  output logic [7:0]       timer2_period,
  output logic [7:0]       serial_slave_address,
  output sfrb_pkg::sfrb_rst_t reset_cause
);
  import sfrb_pkg::*;

  logic [7:0] option_reg;
  logic [7:0] pc_low_reg;
  logic [4:0] pc_upper_reg;
  logic [7:0] status_reg;
  logic [7:0] pointer_reg;
  logic [5:0] dir_a_reg;
  logic [7:0] dir_b_reg;
  logic [7:0] dir_c_reg;
  logic [4:0] program_counter_high_latch_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] pie_reg;
  logic [1:0] power_reset_status_reg;
  logic [7:0] t2_period_reg;
  logic [7:0] serial_addr_reg;
  logic [5:0] serial_state_reg;
  logic [31:0] prdata_next;
  logic       clr_meta_reg;
  logic       clr_sync_reg;
  sfrb_rst_t  cause_reg;
  sfrb_rst_t  cause_next;
  logic       other_rst;
  logic [7:0] idx;
  logic       in_bank;
  logic       wr_acc;
  logic [7:0] wd;
  logic       unimpl;

  sfrb_mem_if #(.AW(8), .DW(8)) mem_bus ();

  sfrb_mem #(.AW(8), .DW(8)) u_mem (
    .mclk (mclk),
    .port (mem_bus.mem)
  );

  // Address decode: index is the byte address divided by four
  assign idx     = {1'b1, paddr[8:2]};
  assign in_bank = (paddr[9:7] == `SFRB_BANK_SEL) && (paddr[1:0] == 2'b00);
  assign wr_acc  = psel && penable && pwrite && in_bank;
  assign wd      = pwdata[7:0];

  // Registers answer at once, so every access phase ends on its first edge
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !in_bank;

  // Clear pin is asynchronous, so two flops come before any use
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clr_meta_reg <= 1'b1;
      clr_sync_reg <= 1'b1;
    end else begin
      clr_meta_reg <= external_clear_pin_n;
      clr_sync_reg <= clr_meta_reg;
    end
  end

  // Non power-up reset cause; watchdog outranks the pin
  always_comb begin
    if (watchdog_timeout) begin
      cause_next = SFRB_RST_WDT;
    end else if (!clr_sync_reg) begin
      cause_next = SFRB_RST_PIN;
    end else begin
      cause_next = SFRB_RST_NONE;
    end
  end
  assign other_rst = (cause_next != SFRB_RST_NONE);

  // Last reset cause, kept for the reset_cause output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cause_reg <= SFRB_RST_NONE;
    end else if (other_rst) begin
      cause_reg <= cause_next;
    end
  end

  // Indirect data port goes straight to memory; nothing is stored here
  assign mem_bus.we    = wr_acc && (idx == `SFRB_IDX_INDIRECT_DATA);
  assign mem_bus.addr  = pointer_reg;
  assign mem_bus.wdata = wd;

  // Option and timer period: same value on every reset type
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      option_reg    <= `SFRB_RST_OPTION;
      t2_period_reg <= `SFRB_RST_T2_PERIOD;
    end else if (other_rst) begin
      option_reg    <= `SFRB_RST_OPTION;
      t2_period_reg <= `SFRB_RST_T2_PERIOD;
    end else if (wr_acc) begin
      if (idx == `SFRB_IDX_OPTION) option_reg <= wd;
      if (idx == `SFRB_IDX_T2_PERIOD) t2_period_reg <= wd;
    end
  end

  // Program counter: writing the low byte pulls the latch into bits 12:8
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_low_reg   <= `SFRB_RST_PC_LOW;
      pc_upper_reg <= `SFRB_RST_PROGRAM_COUNTER_HIGH_LATCH;
      program_counter_high_latch_reg   <= `SFRB_RST_PROGRAM_COUNTER_HIGH_LATCH;
    end else if (other_rst) begin
      pc_low_reg   <= `SFRB_RST_PC_LOW;
      pc_upper_reg <= `SFRB_RST_PROGRAM_COUNTER_HIGH_LATCH;
      program_counter_high_latch_reg   <= `SFRB_RST_PROGRAM_COUNTER_HIGH_LATCH;
    end else if (wr_acc) begin
      if (idx == `SFRB_IDX_PC_LOW) begin
        pc_low_reg   <= wd;
        pc_upper_reg <= program_counter_high_latch_reg;
      end
      if (idx == `SFRB_IDX_PC_HIGH_LATCH) program_counter_high_latch_reg <= wd[4:0];
    end
  end

  // Status: timeout and power-down bits are hardware owned, never written
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= `SFRB_RST_STATUS;
    end else if (other_rst) begin
      status_reg[7:5] <= 3'h0;
      if (cause_next == SFRB_RST_WDT) status_reg[`SFRB_STATUS_TO] <= 1'b0;
    end else if (wr_acc && idx == `SFRB_IDX_STATUS) begin
      status_reg <= (wd & `SFRB_STATUS_WMASK) | (status_reg & ~`SFRB_STATUS_WMASK);
    end
  end

  // Pointer keeps its value across non power-up resets
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pointer_reg <= `SFRB_RST_POINTER;
    end else if (wr_acc && idx == `SFRB_IDX_POINTER) begin
      pointer_reg <= wd;
    end
  end

  // Port directions all return to input on any reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dir_a_reg <= `SFRB_RST_DIR_A;
      dir_b_reg <= `SFRB_RST_DIR_B;
      dir_c_reg <= `SFRB_RST_DIR_C;
    end else if (other_rst) begin
      dir_a_reg <= `SFRB_RST_DIR_A;
      dir_b_reg <= `SFRB_RST_DIR_B;
      dir_c_reg <= `SFRB_RST_DIR_C;
    end else if (wr_acc) begin
      if (idx == `SFRB_IDX_DIR_A) dir_a_reg <= wd[5:0];
      if (idx == `SFRB_IDX_DIR_B) dir_b_reg <= wd;
      if (idx == `SFRB_IDX_DIR_C) dir_c_reg <= wd;
    end
  end

  // Interrupt control; a hardware flag set beats a software clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_control_reg <= `SFRB_RST_INTERRUPT_CONTROL;
    end else if (other_rst) begin
      interrupt_control_reg[7:1] <= 7'h00;
    end else begin
      if (wr_acc && idx == `SFRB_IDX_INT_CONTROL) begin
        interrupt_control_reg <= {wd[7:3], wd[2:0] | int_flag_set};
      end else begin
        interrupt_control_reg[2:0] <= interrupt_control_reg[2:0] | int_flag_set;
      end
    end
  end

  // Peripheral enables; reserved bits 5:4 are forced to zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pie_reg <= `SFRB_RST_PIE;
    end else if (other_rst) begin
      pie_reg <= `SFRB_RST_PIE;
    end else if (wr_acc && idx == `SFRB_IDX_PERIPH_IE) begin
      pie_reg <= wd & `SFRB_PIE_MASK;
    end
  end

  // Power status: cleared by power-up, untouched by other resets, set by software
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      power_reset_status_reg <= `SFRB_RST_POWER_RESET_STATUS;
    end else if (!other_rst && wr_acc && idx == `SFRB_IDX_POWER_STATUS) begin
      power_reset_status_reg <= wd[1:0];
    end
  end

  // Serial address is software owned; serial state only mirrors the port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      serial_addr_reg  <= `SFRB_RST_SERIAL_ADR;
      serial_state_reg <= `SFRB_RST_SERIAL_ST;
    end else if (other_rst) begin
      serial_addr_reg  <= `SFRB_RST_SERIAL_ADR;
      serial_state_reg <= `SFRB_RST_SERIAL_ST;
    end else begin
      serial_state_reg <= serial_port_state_in;
      if (wr_acc && idx == `SFRB_IDX_SERIAL_ADDR) serial_addr_reg <= wd;
    end
  end

  // Read multiplexer; anything not listed reads zero
  always_comb begin
    unimpl      = 1'b0;
    prdata_next = 32'h0000_0000;
    case (idx)
      `SFRB_IDX_INDIRECT_DATA: prdata_next[7:0] = mem_bus.rdata;
      `SFRB_IDX_OPTION:        prdata_next[7:0] = option_reg;
      `SFRB_IDX_PC_LOW:        prdata_next[7:0] = pc_low_reg;
      `SFRB_IDX_STATUS:        prdata_next[7:0] = status_reg;
      `SFRB_IDX_POINTER:       prdata_next[7:0] = pointer_reg;
      `SFRB_IDX_DIR_A:         prdata_next[5:0] = dir_a_reg;
      `SFRB_IDX_DIR_B:         prdata_next[7:0] = dir_b_reg;
      `SFRB_IDX_DIR_C:         prdata_next[7:0] = dir_c_reg;
      `SFRB_IDX_PC_HIGH_LATCH: prdata_next[4:0] = program_counter_high_latch_reg;
      `SFRB_IDX_INT_CONTROL:   prdata_next[7:0] = interrupt_control_reg;
      `SFRB_IDX_PERIPH_IE:     prdata_next[7:0] = pie_reg;
      `SFRB_IDX_POWER_STATUS:  prdata_next[1:0] = power_reset_status_reg;
      `SFRB_IDX_T2_PERIOD:     prdata_next[7:0] = t2_period_reg;
      `SFRB_IDX_SERIAL_ADDR:   prdata_next[7:0] = serial_addr_reg;
      `SFRB_IDX_SERIAL_STATE:  prdata_next[5:0] = serial_state_reg;
      default:                 unimpl = 1'b1;
    endcase
    if (!in_bank) begin
      prdata_next = 32'h0000_0000;
    end
  end

  // Read data driven only during a read access phase
  assign prdata = (psel && penable && !pwrite) ? prdata_next : 32'h0000_0000;

  // Outputs to the core and peripherals
  assign option_config         = option_reg;
  assign core_status           = status_reg;
  assign program_counter       = {pc_upper_reg, pc_low_reg};
  assign port_a_direction      = dir_a_reg;
  assign port_b_direction      = dir_b_reg;
  assign port_c_direction      = dir_c_reg;
  assign interrupt_control     = interrupt_control_reg;
  assign peripheral_irq_enable = pie_reg;
  assign power_reset_status    = power_reset_status_reg;
  assign timer2_period         = t2_period_reg;
  assign serial_slave_address  = serial_addr_reg;
  assign reset_cause           = cause_reg;

  chk_unmapped_reads_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && penable && !pwrite && in_bank && unimpl) |-> (prdata == 32'h0000_0000))
    else $error("unimplemented location read nonzero");

  chk_pc_upper_load: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_acc && idx == `SFRB_IDX_PC_LOW && !other_rst) |=> (program_counter[12:8] == $past(program_counter_high_latch_reg)))
    else $error("latch not moved into upper counter bits");

  chk_latch_write_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_acc && idx == `SFRB_IDX_PC_HIGH_LATCH && !other_rst) |=> (program_counter_high_latch_reg == $past(pwdata[4:0]))
    ##1 (program_counter_high_latch_reg == $past(pwdata[4:0], 2) || $past(other_rst) || $past(wr_acc)))
    else $error("upper latch lost its written value");

  chk_dirs_on_reset: assert property (@(posedge mclk) disable iff (!reset_n)
    other_rst |=> (port_a_direction == 6'h3F && port_b_direction == 8'hFF))
    else $error("port directions not all inputs after reset");

  chk_other_reset_vals: assert property (@(posedge mclk) disable iff (!reset_n)
    other_rst |=> (option_config == 8'hFF && timer2_period == 8'hFF && core_status[7:5] == 3'h0
                   && power_reset_status == $past(power_reset_status_reg)))
    else $error("wrong values after non power-up reset");

  chk_indirect_to_mem: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && penable && !pwrite && in_bank && idx == `SFRB_IDX_INDIRECT_DATA)
    |-> (prdata[7:0] == mem_bus.rdata && mem_bus.addr == pointer_reg))
    else $error("indirect port not tied to memory at pointer");

  chk_pie_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    peripheral_irq_enable[5:4] == 2'b00)
    else $error("unimplemented enable bits set");

  chk_flag_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)
    (int_flag_set[0] && !other_rst) |=> interrupt_control[0])
    else $error("hardware flag set lost to clear");

  chk_out_of_bank: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && penable && !in_bank) |-> (pslverr && prdata == 32'h0000_0000))
    else $error("out of bank access not refused");
endmodule // sfrb_bank1
`default_nettype wire

// ---- testbench/sfrb_core_bfm.sv ----
// Processor core model: issues APB reads and writes to the register bank.
// Assumes the bank answers with pready; a released bus shows no stale data.
`timescale 1ns/1ns
`default_nettype none
module sfrb_core_bfm (
  input  wire logic        mclk,
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic  [9:0]  paddr,
  output var logic  [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idles low from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h00000000;
  end

  // Software habit: bits 7:6 of status and peripheral enable stay clear, brown-out bit stays set
  function automatic logic [7:0] keep_rsvd(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    r = d;
    if (idx == 8'h83 || idx == 8'h8C) r[7:6] = 2'b00;
    if (idx == 8'h8E) r[0] = 1'b1;
    return r;
  endfunction

  // One transfer; the answer is taken at the edge where pready is high
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Request stands until a rising edge sees pready; answer taken at that edge
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~{24'h000000, d}; // Stale data would hide a late capture
  endtask
endmodule // sfrb_core_bfm
`default_nettype wire

// ---- testbench/bank1_special_register_map_tb.sv ----
// Self-checking bench for the second register bank, with a byte model of every index.
// Assumes the core model drives APB and the bench drives resets and status inputs.
`timescale 1ns/1ns
`default_nettype none
`include "sfrb_consts.svh"
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, want); end end
module bank1_special_register_map_tb;
  import sfrb_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        pin_n = 1'b1;
  logic        wdt = 1'b0;
  logic [2:0]  flag_set = 3'h0;
  logic [5:0]  sin = 6'h00;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [9:0]  paddr;
  wire  [31:0] pwdata, prdata;
  wire  [7:0]  opt, sts, dir_b, dir_c, intc, pie, t2p, sad;
  wire  [12:0] pc;
  wire  [5:0]  dir_a;
  wire  [1:0]  pwr;
  sfrb_rst_t   cause;
  int          fails = 0;
  int          num_checks = 0;
  int          seed = 65;
  int          exp[32];
  int          mem[int];
  int          pc_exp;
  logic [31:0] q;
  logic        e;

  sfrb_core_bfm core_u (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sfrb_bank1 dut_u (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clear_pin_n(pin_n), .watchdog_timeout(wdt), .int_flag_set(flag_set),
    .serial_port_state_in(sin), .option_config(opt), .core_status(sts), .program_counter(pc),
    .port_a_direction(dir_a), .port_b_direction(dir_b), .port_c_direction(dir_c),
    .interrupt_control(intc), .peripheral_irq_enable(pie), .power_reset_status(pwr),
    .timer2_period(t2p), .serial_slave_address(sad), .reset_cause(cause));

  // 50 MHz core clock
  always #10 mclk = ~mclk;

  // Writable bits of each index; zero means nothing is stored there
  function automatic int wmask(input int k);
    case (k)
      1, 2, 4, 6, 7, 11, 18, 19: return 'hFF;
      3: return 'hE7;
      5: return 'h3F;
      10: return 'h1F;
      12: return 'hCF;
      14: return 'h03;
      default: return 0;
    endcase
  endfunction

  // Power-up loads everything; other resets keep pointer, power flags, interrupt control bit 0 and some status bits
  task automatic mdl_reset(input bit pwr_up, input bit by_wdt);
    for (int k = 0; k < 32; k++) begin
      if (pwr_up || !(k == 3 || k == 4 || k == 11 || k == 14)) exp[k] = 0;
    end
    exp[1] = 'hFF; exp[5] = 'h3F; exp[6] = 'hFF; exp[7] = 'hFF; exp[18] = 'hFF;
    exp[3] = pwr_up ? 'h18 : (exp[3] & (by_wdt ? 'h0F : 'h1F));
    exp[11] = pwr_up ? 0 : (exp[11] & 1);
    pc_exp = 0;
  endtask

  task automatic put(input int k, input logic [7:0] d);
    logic [7:0] dd;
    dd = core_u.keep_rsvd(8'(k + 'h80), d);
    core_u.xfer(1'b1, {3'b100, 5'(k), 2'b00}, dd, q, e);
    if (k == 0) mem[exp[4]] = dd;
    exp[k] = (exp[k] & ~wmask(k)) | (dd & wmask(k));
    if (k == 2) pc_exp = {exp[10][4:0], dd};
  endtask

  task automatic get(input int k);
    int w;
    // Data memory has no reset, so give the pointed-to word a known value first
    if (k == 0 && !mem.exists(exp[4])) put(0, 8'($random(seed)));
    w = (k == 20) ? sin : (k == 0) ? (mem.exists(exp[4]) ? mem[exp[4]] : 0) : exp[k];
    core_u.xfer(1'b0, {3'b100, 5'(k), 2'b00}, 8'h00, q, e);
    `CHK(q, 32'(w));
    `CHK(e, 1'b0);
  endtask

  // Every readable index and every output port except reset_cause against the model
  task automatic check_all();
    for (int k = 0; k < 32; k++) get(k);
    `CHK({opt, sts, dir_b, dir_c}, {8'(exp[1]), 8'(exp[3]), 8'(exp[6]), 8'(exp[7])});
    `CHK({intc, pie, t2p, sad}, {8'(exp[11]), 8'(exp[12]), 8'(exp[18]), 8'(exp[19])});
    `CHK({dir_a, pwr}, {6'(exp[5]), 2'(exp[14])});
    `CHK(pc, 13'(pc_exp));
  endtask

  task automatic scramble();
    for (int k = 1; k < 32; k++) put(k, 8'($random(seed)));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_sim();
  end

  // Main sequence
  initial begin
    sin <= 6'($random(seed));
    mdl_reset(1'b1, 1'b0);
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    check_all();
    for (int r = 0; r < 3; r++) begin
      scramble();
      check_all();
    end
    // Indirect port follows the pointer
    for (int n = 0; n < 4; n++) begin
      put(4, 8'(n * 37 + 5));
      put(0, 8'($random(seed)));
    end
    for (int n = 3; n >= 0; n--) begin
      put(4, 8'(n * 37 + 5));
      get(0);
    end
    // Out-of-bank and unaligned accesses are refused and store nothing
    core_u.xfer(1'b1, 10'h004, 8'h55, q, e);
    `CHK(e, 1'b1);
    core_u.xfer(1'b0, 10'h205, 8'h00, q, e);
    `CHK({e, q}, 33'h100000000);
    // Interrupt flag pulse
    @(posedge mclk);
    flag_set <= 3'h5;
    @(posedge mclk);
    flag_set <= 3'h0;
    exp[11] = exp[11] | 5;
    check_all();
    // Flag pulse lands on the access edge of a software clear: the set wins
    fork
      put(11, 8'h00);
      begin
        repeat (2) @(posedge mclk);
        flag_set <= 3'h7;
        @(posedge mclk);
        flag_set <= 3'h0;
      end
    join
    exp[11] = exp[11] | 7;
    get(11);
    // Watchdog reset
    scramble();
    wdt <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(cause, SFRB_RST_WDT);
    wdt <= 1'b0;
    @(posedge mclk);
    mdl_reset(1'b0, 1'b1);
    check_all();
    // Clear-pin reset through its synchroniser
    scramble();
    pin_n <= 1'b0;
    repeat (5) @(posedge mclk);
    `CHK(cause, SFRB_RST_PIN);
    pin_n <= 1'b1;
    repeat (4) @(posedge mclk);
    mdl_reset(1'b0, 1'b0);
    check_all();
    // Power-up reset in mid-run
    scramble();
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    mdl_reset(1'b1, 1'b0);
    check_all();
    end_sim();
  end
endmodule // bank1_special_register_map_tb
`default_nettype wire
